// ===== rtl/host_port_pkg.sv
/*
 * Constants shared by the host port strap and trigger block.
 * Assumes a 200 MHz system clock and a plain word-wide register port.
 */
package host_port_pkg;
	// System clock period in picoseconds.
	localparam int MCLK_PERIOD_PS = 5000;
	// Periods of the three selectable device clock rates, in picoseconds.
	localparam int T12_PS = 83333;
	localparam int T16_PS = 62500;
	localparam int T20_PS = 50000;
	// System cycles per device clock period, rounded down.
	localparam int CYC12 = (T12_PS / MCLK_PERIOD_PS < 1) ? 1 : T12_PS / MCLK_PERIOD_PS;
	localparam int CYC16 = (T16_PS / MCLK_PERIOD_PS < 1) ? 1 : T16_PS / MCLK_PERIOD_PS;
	localparam int CYC20 = (T20_PS / MCLK_PERIOD_PS < 1) ? 1 : T20_PS / MCLK_PERIOD_PS;

	// Register byte offsets.
	localparam logic [7:0] OFS_CFG1 = 8'h00;
	localparam logic [7:0] OFS_CLKSEL = 8'h04;
	localparam logic [7:0] OFS_PINSTAT = 8'h08;
	localparam logic [7:0] OFS_FRAMES = 8'h0C;
	localparam logic [7:0] OFS_LASTWR = 8'h10;
	localparam logic [7:0] OFS_STSBASE = 8'h14;

	// Field positions.
	localparam int CFG1_BC_MODE = 0;
	localparam int CFG1_EXT_TRIG_EN = 1;
	localparam int STS_SUBSYS_BIT = 2;
	localparam int PIN_WIDTH_STRAP = 0;
	localparam int PIN_FLAG_LEVEL = 1;
	localparam int PIN_POLARITY = 2;

	// Reset values.
	localparam logic [1:0] CFG1_RESET = 2'h0;
	localparam logic [1:0] CLKSEL_RESET = 2'h0;
	localparam logic [15:0] STSBASE_RESET = 16'h0000;

	// Clock selection codes.
	typedef enum logic [1:0] {
		CLK_12 = 2'b00,
		CLK_16 = 2'b01,
		CLK_20 = 2'b10
	} clk_sel_t;

	// Host cycle states.
	typedef enum logic [1:0] {
		H_IDLE = 2'b00,
		H_WAIT = 2'b01,
		H_DONE = 2'b10
	} host_state_t;
endpackage

// ===== rtl/level_edges.sv
/*
 * Rising and falling edge detector for one synchronous level.
 * Assumes the level is already synchronous to i_mclk.
 */
`timescale 1ns/1ps
`default_nettype none
module level_edges (
	input wire logic i_mclk,
	input wire logic i_rstn,
	input wire logic i_level,
	output logic o_rise,
	output logic o_fall
);
	logic prev_r;
	logic prev_nxt;

	// The previous level simply follows the input.
	always_comb begin
		prev_nxt = i_level;
	end

	// The previous level resets high so that a held-high input gives no false rise.
	always_ff @(posedge i_mclk) begin
		if (!i_rstn) begin
			prev_r <= 1'b1;
		end else begin
			prev_r <= prev_nxt;
		end
	end

	// Edges compare the present level with the stored one.
	assign o_rise = i_level & ~prev_r;
	assign o_fall = ~i_level & prev_r;
endmodule
`default_nettype wire

// ===== rtl/host_port_strap.sv
/*
 * Host port of a serial bus terminal: strap handling, read/write sense,
 * data bus turnaround, clock rate selection, subsystem flag and frame trigger.
 * Assumes all pins are synchronous to i_mclk and the board resolves the data bus.
 */
// What this block does
// - Sense select high: read/write line high reads, low writes.
// - Sense select low: read/write line low reads, high writes.
// - The sense select pin offers no transparent acknowledge function.
// - One input clock; 12, 16 or 20 MHz chosen by configuration.
// - In remote terminal mode a low flag input sets the subsystem flag bit.
// - In controller mode a rising trigger edge starts a frame when enabled.
// - Data lines are sampled on writes and driven by the device on reads.
// - Both buses give positive and negative receiver copies for test.
`timescale 1ns/1ps
`default_nettype none
module host_port_strap #(
	parameter int HOST_WAIT = 2,
	parameter int MEM_DEPTH = 16,
	parameter int HADDR_W = 4
) (
	input wire logic i_mclk,
	input wire logic i_rstn,
	input wire logic [7:0] i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [31:0] o_rdata,
	input wire logic i_width_request_strap,
	input wire logic i_unused_select_strap,
	input wire logic i_polarity_sel,
	input wire logic i_rdwr,
	input wire logic i_host_strobe_n,
	input wire logic [HADDR_W-1:0] i_host_addr,
	input wire logic [15:0] i_data_in,
	output logic [15:0] o_data_out,
	output logic o_data_oe,
	output logic o_host_handshake_n,
	input wire logic i_subsys_fault_or_frame_trigger,
	output logic [15:0] o_status_word,
	output logic o_frame_start,
	output logic o_dev_clk_tick,
	input wire logic i_rx_a,
	input wire logic i_rx_b,
	output logic o_rx_a_pos,
	output logic o_rx_a_neg,
	output logic o_rx_b_pos,
	output logic o_rx_b_neg
);
	logic [1:0] cfg1_r, cfg1_nxt;
	logic [1:0] clksel_r, clksel_nxt;
	logic [15:0] stsbase_r, stsbase_nxt;
	logic [15:0] frames_r, frames_nxt;
	logic [15:0] lastwr_r, lastwr_nxt;
	logic [31:0] rdata_r, rdata_nxt;
	logic trig_rise;
	logic strobe_fall;
	logic is_read;

	// The unused select strap is deliberately left unread.
	// The sense select pin only selects read polarity, never acknowledges.
	assign is_read = i_polarity_sel ? i_rdwr : ~i_rdwr;

	level_edges u_trig_edge (
		.i_mclk(i_mclk),
		.i_rstn(i_rstn),
		.i_level(i_subsys_fault_or_frame_trigger),
		.o_rise(trig_rise),
		.o_fall()
	);

	level_edges u_strobe_edge (
		.i_mclk(i_mclk),
		.i_rstn(i_rstn),
		.i_level(i_host_strobe_n),
		.o_rise(),
		.o_fall(strobe_fall)
	);

	// Register writes, read data and the frame counter.
	always_comb begin
		cfg1_nxt = cfg1_r;
		clksel_nxt = clksel_r;
		stsbase_nxt = stsbase_r;
		frames_nxt = frames_r;
		rdata_nxt = 32'h0000_0000;
		if (i_wr) begin
			case (i_addr)
				host_port_pkg::OFS_CFG1: cfg1_nxt = i_wdata[1:0];
				host_port_pkg::OFS_CLKSEL: clksel_nxt = i_wdata[1:0];
				host_port_pkg::OFS_STSBASE: stsbase_nxt = i_wdata[15:0];
				default: cfg1_nxt = cfg1_r;
			endcase
		end
		if (o_frame_start) begin
			frames_nxt = frames_r + 16'h0001;
		end
		if (i_rd) begin
			case (i_addr)
				host_port_pkg::OFS_CFG1: rdata_nxt = {30'h0000_0000, cfg1_r};
				host_port_pkg::OFS_CLKSEL: rdata_nxt = {30'h0000_0000, clksel_r};
				host_port_pkg::OFS_PINSTAT: begin
					rdata_nxt[host_port_pkg::PIN_WIDTH_STRAP] = i_width_request_strap;
					rdata_nxt[host_port_pkg::PIN_FLAG_LEVEL] = i_subsys_fault_or_frame_trigger;
					rdata_nxt[host_port_pkg::PIN_POLARITY] = i_polarity_sel;
				end
				host_port_pkg::OFS_FRAMES: rdata_nxt = {16'h0000, frames_r};
				host_port_pkg::OFS_LASTWR: rdata_nxt = {16'h0000, lastwr_r};
				host_port_pkg::OFS_STSBASE: rdata_nxt = {16'h0000, stsbase_r};
				default: rdata_nxt = 32'h0000_0000;
			endcase
		end
	end

	// Registers of the software port.
	always_ff @(posedge i_mclk) begin
		if (!i_rstn) begin
			cfg1_r <= host_port_pkg::CFG1_RESET;
			clksel_r <= host_port_pkg::CLKSEL_RESET;
			stsbase_r <= host_port_pkg::STSBASE_RESET;
			frames_r <= 16'h0000;
			rdata_r <= 32'h0000_0000;
		end else begin
			cfg1_r <= cfg1_nxt;
			clksel_r <= clksel_nxt;
			stsbase_r <= stsbase_nxt;
			frames_r <= frames_nxt;
			rdata_r <= rdata_nxt;
		end
	end
	assign o_rdata = rdata_r;

	// Device clock rate divider; the rate is chosen by software, not detected.
	logic [4:0] div_r, div_nxt;
	logic tick_r, tick_nxt;
	logic [4:0] div_last;
	always_comb begin
		case (clksel_r)
			host_port_pkg::CLK_12: div_last = 5'(host_port_pkg::CYC12 - 1);
			host_port_pkg::CLK_16: div_last = 5'(host_port_pkg::CYC16 - 1);
			default: div_last = 5'(host_port_pkg::CYC20 - 1);
		endcase
		div_nxt = (div_r >= div_last) ? 5'h00 : div_r + 5'h01;
		tick_nxt = (div_r >= div_last);
	end

	// Divider state.
	always_ff @(posedge i_mclk) begin
		if (!i_rstn) begin
			div_r <= 5'h00;
			tick_r <= 1'b0;
		end else begin
			div_r <= div_nxt;
			tick_r <= tick_nxt;
		end
	end
	assign o_dev_clk_tick = tick_r;

	// Status word and frame start derived from the shared flag/trigger pin.
	logic [15:0] sts_r, sts_nxt;
	logic frame_r, frame_nxt;
	always_comb begin
		sts_nxt = stsbase_r;
		if (!cfg1_r[host_port_pkg::CFG1_BC_MODE] && !i_subsys_fault_or_frame_trigger) begin
			sts_nxt[host_port_pkg::STS_SUBSYS_BIT] = 1'b1;
		end
		frame_nxt = cfg1_r[host_port_pkg::CFG1_BC_MODE] &
			cfg1_r[host_port_pkg::CFG1_EXT_TRIG_EN] & trig_rise;
	end

	// Flag and trigger outputs.
	always_ff @(posedge i_mclk) begin
		if (!i_rstn) begin
			sts_r <= 16'h0000;
			frame_r <= 1'b0;
		end else begin
			sts_r <= sts_nxt;
			frame_r <= frame_nxt;
		end
	end
	assign o_status_word = sts_r;
	assign o_frame_start = frame_r;

	// Receiver test copies in both polarities.
	logic [3:0] rx_r, rx_nxt;
	always_comb begin
		rx_nxt = {~i_rx_b, i_rx_b, ~i_rx_a, i_rx_a};
	end

	// Receiver copy registers.
	always_ff @(posedge i_mclk) begin
		if (!i_rstn) begin
			rx_r <= 4'h0;
		end else begin
			rx_r <= rx_nxt;
		end
	end
	assign o_rx_a_pos = rx_r[0];
	assign o_rx_a_neg = rx_r[1];
	assign o_rx_b_pos = rx_r[2];
	assign o_rx_b_neg = rx_r[3];

	// Host cycle: shared word memory, data bus turnaround and handshake.
	logic [15:0] mem [MEM_DEPTH];
	host_port_pkg::host_state_t hst_r, hst_nxt;
	logic [7:0] hcnt_r, hcnt_nxt;
	logic [15:0] dout_r, dout_nxt;
	logic doe_r, doe_nxt;
	logic hs_n_r, hs_n_nxt;
	logic mem_we;
	always_comb begin
		hst_nxt = hst_r;
		hcnt_nxt = hcnt_r;
		dout_nxt = dout_r;
		doe_nxt = doe_r;
		hs_n_nxt = hs_n_r;
		lastwr_nxt = lastwr_r;
		mem_we = 1'b0;
		case (hst_r)
			host_port_pkg::H_IDLE: begin
				if (strobe_fall) begin
					hst_nxt = host_port_pkg::H_WAIT;
					hcnt_nxt = 8'h00;
					if (is_read) begin
						dout_nxt = mem[i_host_addr];
						doe_nxt = 1'b1;
					end else begin
						mem_we = 1'b1;
						lastwr_nxt = i_data_in;
					end
				end
			end
			host_port_pkg::H_WAIT: begin
				if (hcnt_r >= 8'(HOST_WAIT)) begin
					hst_nxt = host_port_pkg::H_DONE;
					hs_n_nxt = 1'b0;
				end else begin
					hcnt_nxt = hcnt_r + 8'h01;
				end
			end
			host_port_pkg::H_DONE: begin
				if (i_host_strobe_n) begin
					hst_nxt = host_port_pkg::H_IDLE;
					hs_n_nxt = 1'b1;
					doe_nxt = 1'b0;
				end
			end
			default: hst_nxt = host_port_pkg::H_IDLE;
		endcase
	end

	// Host cycle state and memory.
	always_ff @(posedge i_mclk) begin
		if (!i_rstn) begin
			hst_r <= host_port_pkg::H_IDLE;
			hcnt_r <= 8'h00;
			dout_r <= 16'h0000;
			doe_r <= 1'b0;
			hs_n_r <= 1'b1;
			lastwr_r <= 16'h0000;
		end else begin
			hst_r <= hst_nxt;
			hcnt_r <= hcnt_nxt;
			dout_r <= dout_nxt;
			doe_r <= doe_nxt;
			hs_n_r <= hs_n_nxt;
			lastwr_r <= lastwr_nxt;
		end
		if (mem_we) begin
			mem[i_host_addr] <= i_data_in;
		end
	end
	assign o_data_out = dout_r;
	assign o_data_oe = doe_r;
	assign o_host_handshake_n = hs_n_r;

	// Goes high one edge after reset is released. The checks below stay off until then,
	// because in the release cycle the outputs still show their reset values.
	logic live_r, live_nxt;
	always_comb begin
		live_nxt = 1'b1;
	end

	// Check enable register; it drops at the same edge that resets the block.
	always_ff @(posedge i_mclk) begin
		if (!i_rstn) begin
			live_r <= 1'b0;
		end else begin
			live_r <= live_nxt;
		end
	end

	a_flag_sets_bit: assert property (@(posedge i_mclk) disable iff (!live_r)
		(!cfg1_r[0] && !i_subsys_fault_or_frame_trigger) |=> o_status_word[2])
		else $error("Subsystem flag bit not set.");
	a_flag_clear_bit: assert property (@(posedge i_mclk) disable iff (!live_r)
		(!cfg1_r[0] && i_subsys_fault_or_frame_trigger) |=> o_status_word[2] == $past(stsbase_r[2]))
		else $error("Subsystem flag bit wrongly forced.");
	a_trig_frame: assert property (@(posedge i_mclk) disable iff (!live_r)
		(cfg1_r == 2'h3 && trig_rise) |=> o_frame_start)
		else $error("Enabled trigger edge did not start a frame.");
	a_trig_gated: assert property (@(posedge i_mclk) disable iff (!live_r)
		(cfg1_r != 2'h3) |=> !o_frame_start)
		else $error("Frame started without trigger enable.");
	a_read_drives: assert property (@(posedge i_mclk) disable iff (!live_r)
		(hst_r == host_port_pkg::H_IDLE && strobe_fall && i_polarity_sel && i_rdwr) |=> o_data_oe)
		else $error("High-sense read did not drive the bus.");
	a_write_quiet: assert property (@(posedge i_mclk) disable iff (!live_r)
		(hst_r == host_port_pkg::H_IDLE && strobe_fall && !i_polarity_sel && i_rdwr) |=> !o_data_oe)
		else $error("Low-sense write drove the bus.");
	a_write_stored: assert property (@(posedge i_mclk) disable iff (!live_r)
		(hst_r == host_port_pkg::H_IDLE && strobe_fall && !is_read) |=> lastwr_r == $past(i_data_in))
		else $error("Written host word not captured.");
	a_handshake_wait: assert property (@(posedge i_mclk) disable iff (!live_r)
		(hst_r == host_port_pkg::H_IDLE && strobe_fall) |=> o_host_handshake_n [*2])
		else $error("Handshake asserted too early.");
	a_rx_copies: assert property (@(posedge i_mclk) disable iff (!live_r)
		##1 (o_rx_a_pos == $past(i_rx_a)) && (o_rx_b_neg == !$past(i_rx_b)))
		else $error("Receiver test copies wrong.");
	a_tick_period: assert property (@(posedge i_mclk) disable iff (!live_r)
		(o_dev_clk_tick && clksel_r == 2'h2 && $stable(clksel_r)) |=> !o_dev_clk_tick [*8])
		else $error("Device clock tick too frequent.");
endmodule
`default_nettype wire

// ===== verification/host_cpu_model.sv
/*
 * Host processor model that runs word transfers on the host port.
 * Assumes handshake, data enable and data output are registered by the device.
 */
`timescale 1ns/1ps
`default_nettype none
module host_cpu_model (
	input wire logic i_mclk,
	input wire logic i_pol,
	input wire logic i_hs_n,
	input wire logic [15:0] i_dout,
	input wire logic i_oe,
	output logic o_strobe_n,
	output logic o_rdwr,
	output logic [3:0] o_addr,
	output logic [15:0] o_data
);
	initial begin
		o_strobe_n = 1'b1;
		o_rdwr = 1'b1;
		o_addr = 4'h0;
		o_data = 16'h0000;
	end

	// One 16-bit transfer; the strobe is held low until the handshake is seen low or 40 cycles pass.
	task automatic xfer(input logic rd, input logic [3:0] a, input logic [15:0] d,
		output logic [15:0] q, output logic oe_seen, output logic ok);
		int n;
		n = 0;
		oe_seen = 1'b0;
		ok = 1'b0;
		@(posedge i_mclk);
		o_strobe_n <= 1'b0;
		o_rdwr <= rd ? i_pol : ~i_pol;
		o_addr <= a;
		o_data <= rd ? ~o_data : d;
		while (n < 40 && !ok) begin
			@(posedge i_mclk);
			#1;
			oe_seen = oe_seen | (i_oe === 1'b1);
			ok = (i_hs_n === 1'b0);
			n++;
		end
		q = i_dout;
		@(posedge i_mclk);
		o_strobe_n <= 1'b1;
		// A released bus shows the inverse of its last value.
		o_data <= ~o_data;
	endtask
endmodule
`default_nettype wire

// ===== verification/host_port_strap_tb_top.sv
/*
 * Self-checking bench for the host port strap and trigger block.
 * Assumes the default host wait count and a 4-bit host address.
 */
`timescale 1ns/1ps
`default_nettype none
module host_port_strap_tb_top;
	logic i_mclk = 1'b0;
	logic i_rstn = 1'b0;
	logic [7:0] i_addr = 8'h00;
	logic [31:0] i_wdata = 32'h0;
	logic i_wr = 1'b0;
	logic i_rd = 1'b0;
	logic pol = 1'b1;
	logic unused = 1'b0;
	logic trig = 1'b0;
	logic rx_a = 1'b0;
	logic rx_b = 1'b0;
	logic [31:0] o_rdata;
	logic strobe_n, rdwr, oe, hs_n, fstart, tick, a_pos, a_neg, b_pos, b_neg;
	logic [3:0] haddr;
	logic [15:0] hdata, dout, status;
	int bad_count = 0;
	int total_checks = 0;
	int cyc = 0;
	int fcount = 0;
	int last_tick = 0;
	int tick_per = 0;

	// The clock toggles every half period of 2.5 ns.
	always #2.5 i_mclk = ~i_mclk;

	host_port_strap u_dut (.i_mclk(i_mclk), .i_rstn(i_rstn), .i_addr(i_addr),
		.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
		.i_width_request_strap(1'b1), .i_unused_select_strap(unused),
		.i_polarity_sel(pol), .i_rdwr(rdwr), .i_host_strobe_n(strobe_n),
		.i_host_addr(haddr), .i_data_in(hdata), .o_data_out(dout), .o_data_oe(oe),
		.o_host_handshake_n(hs_n), .i_subsys_fault_or_frame_trigger(trig),
		.o_status_word(status), .o_frame_start(fstart), .o_dev_clk_tick(tick),
		.i_rx_a(rx_a), .i_rx_b(rx_b), .o_rx_a_pos(a_pos), .o_rx_a_neg(a_neg),
		.o_rx_b_pos(b_pos), .o_rx_b_neg(b_neg));

	host_cpu_model u_host (.i_mclk(i_mclk), .i_pol(pol), .i_hs_n(hs_n), .i_dout(dout),
		.i_oe(oe), .o_strobe_n(strobe_n), .o_rdwr(rdwr), .o_addr(haddr), .o_data(hdata));

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		total_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("mismatch at %0t: %s got %h expected %h", $time, m, got, exp);
		end
	endtask

	task automatic wreg(input logic [7:0] a, input logic [31:0] d);
		@(posedge i_mclk);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_mclk);
		i_wr <= 1'b0;
	endtask

	task automatic rreg(input logic [7:0] a, input logic [31:0] exp, input string m);
		@(posedge i_mclk);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_mclk);
		i_rd <= 1'b0;
		#1;
		chk(o_rdata, exp, m);
	endtask

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// Counts frame pulses, measures tick spacing and cuts a hang short.
	always @(posedge i_mclk) begin
		cyc++;
		if (fstart === 1'b1) fcount++;
		if (tick === 1'b1) begin
			tick_per = cyc - last_tick;
			last_tick = cyc;
		end
		if (cyc == 5000) begin
			bad_count++;
			give_verdict();
		end
	end

	// Runs the tests in order.
	initial begin
		logic [15:0] q;
		logic oes, ok;
		int f0;
		repeat (6) @(posedge i_mclk);
		i_rstn <= 1'b1;
		#1;
		chk({oe, hs_n, fstart}, 32'h2, "reset outputs");
		rreg(host_port_pkg::OFS_PINSTAT, 32'h5, "pin levels");
		wreg(host_port_pkg::OFS_PINSTAT, 32'hFFFF);
		rreg(host_port_pkg::OFS_PINSTAT, 32'h5, "read-only pins");
		rreg(8'h40, 32'h0, "unmapped read");
		$display("test straps done");
		wreg(host_port_pkg::OFS_STSBASE, 32'h1230);
		wreg(host_port_pkg::OFS_CFG1, 32'h0);
		repeat (3) @(posedge i_mclk);
		chk(status, 32'h1234, "flag low in RT");
		trig <= 1'b1;
		repeat (3) @(posedge i_mclk);
		chk(status, 32'h1230, "flag high in RT");
		$display("test status done");
		wreg(host_port_pkg::OFS_CFG1, 32'h1);
		trig <= 1'b0;
		repeat (3) @(posedge i_mclk);
		f0 = fcount;
		trig <= 1'b1;
		repeat (6) @(posedge i_mclk);
		chk(fcount - f0, 32'h0, "trigger disabled");
		trig <= 1'b0;
		wreg(host_port_pkg::OFS_CFG1, 32'h3);
		trig <= 1'b1;
		repeat (6) @(posedge i_mclk);
		chk(fcount - f0, 32'h1, "trigger enabled");
		rreg(host_port_pkg::OFS_FRAMES, 32'h1, "frame count");
		$display("test trigger done");
		for (int p = 0; p < 2; p++) begin
			@(posedge i_mclk);
			pol <= p[0];
			unused <= ~p[0];
			u_host.xfer(1'b0, 4'h3 + p[3:0], 16'hA5C3 ^ p[15:0], q, oes, ok);
			chk({ok, oes}, 32'h2, "write cycle");
			rreg(host_port_pkg::OFS_LASTWR, 32'hA5C3 ^ p, "last write");
			u_host.xfer(1'b1, 4'h3 + p[3:0], 16'h0000, q, oes, ok);
			chk({ok, oes, q}, 32'h3A5C3 ^ p, "read cycle");
		end
		$display("test host port done");
		for (int s = 0; s < 4; s++) begin
			wreg(host_port_pkg::OFS_CLKSEL, s);
			repeat (40) @(posedge i_mclk);
			chk(tick_per, (s == 0) ? host_port_pkg::CYC12 : (s == 1) ?
				host_port_pkg::CYC16 : host_port_pkg::CYC20, "tick period");
		end
		$display("test clock select done");
		rx_a <= 1'b1;
		repeat (3) @(posedge i_mclk);
		chk({a_pos, a_neg, b_pos, b_neg}, 32'h9, "receiver copies");
		rx_a <= 1'b0;
		rx_b <= 1'b1;
		repeat (3) @(posedge i_mclk);
		chk({a_pos, a_neg, b_pos, b_neg}, 32'h6, "receiver copies");
		$display("test receivers done");
		give_verdict();
	end
endmodule
`default_nettype wire
